// ---- design/pxc_pkg.sv ----
// Constants, types and register map for the proximity offset/calibration control.
// Assumes one clock domain; the host reaches registers over the I2C pins.
package pxc_pkg;

    // ==================== register offsets
    localparam logic [7:0] ADDR_STATUS   = 8'h93;
    localparam logic [7:0] ADDR_PROX     = 8'h9C;
    localparam logic [7:0] ADDR_AUX      = 8'h9E;
    localparam logic [7:0] ADDR_INTERRUPT_SLEEP_CONFIG     = 8'hAB;
    localparam logic [7:0] ADDR_OFS_MAG  = 8'hC0;
    localparam logic [7:0] ADDR_OFS_SIGN = 8'hC1;
    localparam logic [7:0] ADDR_CAL      = 8'hD7;

    // ==================== field positions
    localparam int CFG_RDCLR_BIT = 7;
    localparam int CFG_SAI_BIT   = 4;
    localparam int CAL_ELEC_BIT  = 5;
    localparam int CAL_START_BIT = 0;
    localparam int ST_PSAT_BIT   = 6;
    localparam int ST_PINT_BIT   = 5;
    localparam int ST_CINT_BIT   = 3;

    // ==================== reset values and masks
    localparam logic [7:0] STATUS_RST  = 8'h00;
    localparam logic [7:0] STATUS_MASK = 8'h6F;
    localparam logic [7:0] INTERRUPT_SLEEP_CONFIG_RST    = 8'h0C;
    localparam logic [7:0] INTERRUPT_SLEEP_CONFIG_WMASK  = 8'h9F;
    localparam logic [7:0] PROX_RST    = 8'h00;
    localparam logic [7:0] OFS_RST     = 8'h00;
    // arbitrary auxiliary id and bus address
    localparam logic [3:0] AUXILIARY_IDENT      = 4'hA;
    localparam logic [6:0] I2C_ADDR    = 7'h39;
    localparam logic [3:0] BITS_BYTE   = 4'h8;

    // ==================== types
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pxc_req_t;

    typedef struct packed {
        logic       sign;
        logic [7:0] mag;
    } pxc_cal_res_t;

    typedef enum logic {CAL_IDLE, CAL_RUN} pxc_cal_state_t;
    typedef enum logic [2:0] {I2C_IDLE, I2C_RX, I2C_ACK, I2C_TX, I2C_RACK} pxc_i2c_state_t;
    typedef enum logic [1:0] {PH_ADDR, PH_REG, PH_DATA} pxc_phase_t;

endpackage

// ---- design/pxc_i2c_target.sv ----
// I2C target: address byte, register pointer byte, then data with pointer auto-increment.
// Assumes SCL/SDA arrive asynchronously and SDA is open drain, resolved outside.
`timescale 1ns/1ps
module pxc_i2c_target
    import pxc_pkg::*;
(
    // clock and reset
    input  wire logic       i_clock,
    input  wire logic       i_rst,
    // bus pins
    input  wire logic       i_scl,
    input  wire logic       i_sda,
    output logic            o_sda_out,
    output logic            o_sda_oe_n,
    // register access
    output pxc_req_t        o_req,
    input  wire logic [7:0] i_rdata
);

    // ==================== pin filtering
    logic [2:0]     scl_sync_reg;
    logic [2:0]     sda_sync_reg;
    logic           scl_reg;
    logic           sda_reg;
    logic           scl_prev_reg;
    logic           sda_prev_reg;
    pxc_i2c_state_t state_reg, state_next;
    pxc_phase_t     phase_reg, phase_next;
    logic           rw_reg, rw_next;
    logic           ack_reg, ack_next;
    logic [3:0]     cnt_reg, cnt_next;
    logic [7:0]     shift_reg, shift_next;
    logic [7:0]     ptr_reg, ptr_next;
    logic           wr_next;
    logic           rd_next;

    // a change counts only once stages two and three agree
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            scl_sync_reg <= 3'h7;
            sda_sync_reg <= 3'h7;
            scl_reg      <= 1'b1;
            sda_reg      <= 1'b1;
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
        end
        else
        begin
            scl_sync_reg <= {scl_sync_reg[1:0], i_scl};
            sda_sync_reg <= {sda_sync_reg[1:0], i_sda};
            if (scl_sync_reg[2] == scl_sync_reg[1])
                scl_reg <= scl_sync_reg[2];
            if (sda_sync_reg[2] == sda_sync_reg[1])
                sda_reg <= sda_sync_reg[2];
            scl_prev_reg <= scl_reg;
            sda_prev_reg <= sda_reg;
        end
    end

    wire scl_rise = scl_reg & ~scl_prev_reg;
    wire scl_fall = ~scl_reg & scl_prev_reg;
    wire start_c  = scl_reg & scl_prev_reg & sda_prev_reg & ~sda_reg;
    wire stop_c   = scl_reg & scl_prev_reg & ~sda_prev_reg & sda_reg;

    // ==================== protocol
    always_comb
    begin
        state_next = state_reg;
        phase_next = phase_reg;
        rw_next    = rw_reg;
        ack_next   = ack_reg;
        cnt_next   = cnt_reg;
        shift_next = shift_reg;
        ptr_next   = ptr_reg;
        wr_next    = 1'b0;
        rd_next    = 1'b0;
        if (start_c)
        begin
            state_next = I2C_RX;
            phase_next = PH_ADDR;
            cnt_next   = 4'h0;
        end
        else if (stop_c)
            state_next = I2C_IDLE;
        else
            unique case (state_reg)
                I2C_IDLE: ;
                I2C_RX:
                    if (scl_rise)
                    begin
                        shift_next = {shift_reg[6:0], sda_reg};
                        cnt_next   = cnt_reg + 4'h1;
                    end
                    else if (scl_fall && cnt_reg == BITS_BYTE)
                    begin
                        cnt_next   = 4'h0;
                        state_next = I2C_ACK;
                        if (phase_reg == PH_ADDR)
                        begin
                            if (shift_reg[7:1] != I2C_ADDR)
                                state_next = I2C_IDLE;
                            rw_next = shift_reg[0];
                        end
                        else if (phase_reg == PH_REG)
                            ptr_next = shift_reg;
                        else
                        begin
                            wr_next  = 1'b1;
                            ptr_next = ptr_reg + 8'h01;
                        end
                    end
                I2C_ACK:
                    if (scl_fall)
                    begin
                        if (phase_reg == PH_ADDR && rw_reg)
                        begin
                            state_next = I2C_TX;
                            shift_next = i_rdata;
                            rd_next    = 1'b1;
                            ptr_next   = ptr_reg + 8'h01;
                        end
                        else
                        begin
                            state_next = I2C_RX;
                            phase_next = (phase_reg == PH_ADDR) ? PH_REG : PH_DATA;
                        end
                    end
                I2C_TX:
                    if (scl_fall)
                    begin
                        if (cnt_reg == BITS_BYTE - 4'h1)
                        begin
                            state_next = I2C_RACK;
                            cnt_next   = 4'h0;
                        end
                        else
                        begin
                            shift_next = {shift_reg[6:0], 1'b0};
                            cnt_next   = cnt_reg + 4'h1;
                        end
                    end
                I2C_RACK:
                    if (scl_rise)
                        ack_next = ~sda_reg;
                    else if (scl_fall)
                    begin
                        state_next = ack_reg ? I2C_TX : I2C_IDLE;
                        shift_next = i_rdata;
                        rd_next    = ack_reg;
                        ptr_next   = ack_reg ? ptr_reg + 8'h01 : ptr_reg;
                    end
                default:
                    state_next = I2C_IDLE;
            endcase
    end

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_reg <= I2C_IDLE;
            phase_reg <= PH_ADDR;
            rw_reg    <= 1'b0;
            ack_reg   <= 1'b0;
            cnt_reg   <= 4'h0;
            shift_reg <= 8'h00;
            ptr_reg   <= 8'h00;
        end
        else
        begin
            state_reg <= state_next;
            phase_reg <= phase_next;
            rw_reg    <= rw_next;
            ack_reg   <= ack_next;
            cnt_reg   <= cnt_next;
            shift_reg <= shift_next;
            ptr_reg   <= ptr_next;
        end
    end

    // read strobe fires in the same cycle the byte is captured, so clear-on-read
    // cannot swallow an event that lands between capture and clear
    assign o_req.wr    = wr_next;
    assign o_req.rd    = rd_next;
    assign o_req.addr  = ptr_reg;
    assign o_req.wdata = shift_reg;
    assign o_sda_out   = 1'b0;
    assign o_sda_oe_n  = ~((state_reg == I2C_ACK) | ((state_reg == I2C_TX) & ~shift_reg[7]));

endmodule

// ---- design/pxc_core.sv ----
// Proximity register file, offset calibration control and oscillator gating.
// Assumes analog side runs on i_clock and delivers single-cycle event pulses.
`timescale 1ns/1ps
module pxc_core
    import pxc_pkg::*;
(
    // clock and reset
    input  wire logic         i_clock,
    input  wire logic         i_rst,
    // host bus pins
    input  wire logic         i_scl,
    input  wire logic         i_sda,
    output logic              o_sda_out,
    output logic              o_sda_oe_n,
    // interrupt pin, open drain, active low
    output logic              o_int_out,
    output logic              o_int_oe_n,
    // power and oscillator
    input  wire logic         i_power_on,
    output logic              o_osc_enable,
    // proximity engine
    input  wire logic         i_prox_valid,
    input  wire logic [7:0]   i_prox_count,
    input  wire logic [7:0]   i_status_set,
    // calibration engine
    output logic              o_cal_run,
    output logic              o_cal_electrical,
    input  wire logic         i_cal_done,
    input  wire pxc_cal_res_t i_cal_result
);

    // ==================== bus target
    pxc_req_t       req;
    logic [7:0]     rdata;
    logic [7:0]     status_reg, status_next;
    logic [7:0]     cfg_reg, cfg_next;
    logic [7:0]     prox_reg, prox_next;
    logic [7:0]     ofs_mag_reg, ofs_mag_next;
    logic           ofs_sign_reg, ofs_sign_next;
    logic           cal_start_reg, cal_start_next;
    logic           cal_elec_reg, cal_elec_next;
    logic           run_elec_reg, run_elec_next;
    logic           pon_seen_reg;
    logic           int_reg;
    logic           sleep_reg, sleep_next;
    logic           osc_reg;
    pxc_cal_state_t cal_state, cal_state_next;

    pxc_i2c_target u_i2c (
        .i_clock    (i_clock),
        .i_rst      (i_rst),
        .i_scl      (i_scl),
        .i_sda      (i_sda),
        .o_sda_out  (o_sda_out),
        .o_sda_oe_n (o_sda_oe_n),
        .o_req      (req),
        .i_rdata    (rdata)
    );

    // ==================== decode
    wire sel_status = req.addr == ADDR_STATUS;
    wire wr_status  = req.wr & sel_status;
    wire rd_status  = req.rd & sel_status;
    wire wr_cfg     = req.wr & (req.addr == ADDR_INTERRUPT_SLEEP_CONFIG);
    wire wr_cal     = req.wr & (req.addr == ADDR_CAL);
    wire start_wr   = wr_cal & req.wdata[CAL_START_BIT];
    wire stop_wr    = wr_cal & ~req.wdata[CAL_START_BIT];
    wire cal_idle   = cal_state == CAL_IDLE;
    wire auto_cal   = i_power_on & ~pon_seen_reg & cal_idle;
    wire cal_go     = cal_idle & (start_wr | auto_cal);
    wire cal_abort  = ~cal_idle & stop_wr;
    wire cal_fin    = ~cal_idle & ~stop_wr & i_cal_done;

    // ==================== readback
    wire [7:0] cal_rd = {2'b00, cal_elec_reg, 4'h0, cal_start_reg};
    assign rdata = sel_status                  ? status_reg           :
                   (req.addr == ADDR_PROX)     ? prox_reg             :
                   (req.addr == ADDR_AUX)      ? {4'h0, AUXILIARY_IDENT}       :
                   (req.addr == ADDR_INTERRUPT_SLEEP_CONFIG)     ? cfg_reg              :
                   (req.addr == ADDR_OFS_MAG)  ? ofs_mag_reg          :
                   (req.addr == ADDR_OFS_SIGN) ? {7'h00, ofs_sign_reg} :
                   (req.addr == ADDR_CAL)      ? cal_rd               :
                                                 8'h00;

    // ==================== status flags
    // psat write also clears both of its source bits
    wire [7:0] wr_clr = wr_status
                      ? (req.wdata | {6'h00, {2{req.wdata[ST_PSAT_BIT]}}})
                      : 8'h00;
    wire [7:0] rd_clr = (rd_status & cfg_reg[CFG_RDCLR_BIT]) ? 8'hFF : 8'h00;
    wire [7:0] set_vec = i_status_set | ({7'h00, cal_fin} << ST_CINT_BIT);
    // a set always wins over a clear in the same cycle
    assign status_next = ((status_reg & ~(wr_clr | rd_clr)) | set_vec) & STATUS_MASK;

    // ==================== configuration and data
    assign cfg_next  = wr_cfg ? (req.wdata & INTERRUPT_SLEEP_CONFIG_WMASK) : cfg_reg;
    assign prox_next = i_prox_valid ? i_prox_count : prox_reg;

    // ==================== calibration control
    always_comb
    begin
        cal_state_next = cal_state;
        unique case (cal_state)
            CAL_IDLE:
                if (cal_go)
                    cal_state_next = CAL_RUN;
            CAL_RUN:
                if (cal_abort || cal_fin)
                    cal_state_next = CAL_IDLE;
        endcase
    end

    // mode is frozen at start; the power-up run is always electrical
    assign run_elec_next = cal_go
                         ? (auto_cal | (wr_cal ? req.wdata[CAL_ELEC_BIT] : cal_elec_reg))
                         : run_elec_reg;
    assign cal_elec_next = cal_fin ? 1'b0
                         : (wr_cal ? req.wdata[CAL_ELEC_BIT] : (cal_elec_reg | auto_cal));
    assign cal_start_next = (cal_fin | cal_abort) ? 1'b0
                          : (cal_go | (wr_cal ? req.wdata[CAL_START_BIT] : cal_start_reg));
    assign ofs_mag_next  = cal_fin ? i_cal_result.mag : ofs_mag_reg;
    assign ofs_sign_next = cal_fin ? i_cal_result.sign : ofs_sign_reg;

    // ==================== oscillator gating
    // sleep only from the interrupt line, no register is touched; clearing the
    // flags drops the interrupt and releases sleep
    assign sleep_next = i_power_on & cfg_reg[CFG_SAI_BIT] & int_reg
                      & (sleep_reg | i_prox_valid);

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            status_reg    <= STATUS_RST;
            cfg_reg       <= INTERRUPT_SLEEP_CONFIG_RST;
            prox_reg      <= PROX_RST;
            ofs_mag_reg   <= OFS_RST;
            ofs_sign_reg  <= 1'b0;
            cal_state     <= CAL_IDLE;
            cal_start_reg <= 1'b0;
            cal_elec_reg  <= 1'b0;
            run_elec_reg  <= 1'b0;
            pon_seen_reg  <= 1'b0;
            int_reg       <= 1'b0;
            sleep_reg     <= 1'b0;
            osc_reg       <= 1'b0;
        end
        else
        begin
            status_reg    <= status_next;
            cfg_reg       <= cfg_next;
            prox_reg      <= prox_next;
            ofs_mag_reg   <= ofs_mag_next;
            ofs_sign_reg  <= ofs_sign_next;
            cal_state     <= cal_state_next;
            cal_start_reg <= cal_start_next;
            cal_elec_reg  <= cal_elec_next;
            run_elec_reg  <= run_elec_next;
            pon_seen_reg  <= pon_seen_reg | auto_cal;
            int_reg       <= |status_next;
            sleep_reg     <= sleep_next;
            osc_reg       <= i_power_on & ~sleep_next;
        end
    end

    assign o_int_out        = 1'b0;
    assign o_int_oe_n       = ~int_reg;
    assign o_osc_enable     = osc_reg;
    assign o_cal_run        = cal_state == CAL_RUN;
    assign o_cal_electrical = run_elec_reg;

    // ==================== assertions
    property p_prox_load;
        @(posedge i_clock) disable iff (i_rst)
        i_prox_valid |=> prox_reg == $past(i_prox_count);
    endproperty
    a_prox_load: assert property (p_prox_load)
        else $error("proximity count not loaded");

    property p_prox_ro;
        @(posedge i_clock) disable iff (i_rst)
        req.wr && req.addr == ADDR_PROX && !i_prox_valid |=> $stable(prox_reg);
    endproperty
    a_prox_ro: assert property (p_prox_ro)
        else $error("write changed proximity count");

    property p_rd_clear;
        @(posedge i_clock) disable iff (i_rst)
        rd_status && cfg_reg[CFG_RDCLR_BIT] && set_vec == 8'h00 |=> status_reg == 8'h00;
    endproperty
    a_rd_clear: assert property (p_rd_clear)
        else $error("status not cleared by read");

    property p_rd_keep;
        @(posedge i_clock) disable iff (i_rst)
        rd_status && !cfg_reg[CFG_RDCLR_BIT]
        |=> (status_reg & $past(status_reg)) == $past(status_reg);
    endproperty
    a_rd_keep: assert property (p_rd_keep)
        else $error("status lost on plain read");

    property p_osc_off;
        @(posedge i_clock) disable iff (i_rst)
        !i_power_on |=> !o_osc_enable;
    endproperty
    a_osc_off: assert property (p_osc_off)
        else $error("oscillator on without power");

    property p_sleep_cause;
        @(posedge i_clock) disable iff (i_rst)
        i_power_on && !o_osc_enable && $past(i_power_on)
        |-> $past(int_reg) && $past(cfg_reg[CFG_SAI_BIT]);
    endproperty
    a_sleep_cause: assert property (p_sleep_cause)
        else $error("sleep without interrupt");

    property p_cal_store;
        @(posedge i_clock) disable iff (i_rst)
        cal_fin |=> ofs_mag_reg == $past(i_cal_result.mag)
                 && ofs_sign_reg == $past(i_cal_result.sign)
                 && !cal_elec_reg && !cal_start_reg && status_reg[ST_CINT_BIT];
    endproperty
    a_cal_store: assert property (p_cal_store)
        else $error("calibration result not stored");

    property p_abort;
        @(posedge i_clock) disable iff (i_rst)
        cal_abort |=> cal_state == CAL_IDLE && !cal_start_reg && !o_cal_run;
    endproperty
    a_abort: assert property (p_abort)
        else $error("calibration not aborted");

    property p_auto;
        @(posedge i_clock) disable iff (i_rst)
        auto_cal |=> o_cal_run && o_cal_electrical ##1 !auto_cal;
    endproperty
    a_auto: assert property (p_auto)
        else $error("power-up calibration missing");

    property p_cint_w1c;
        @(posedge i_clock) disable iff (i_rst)
        wr_status && req.wdata[ST_CINT_BIT] && !set_vec[ST_CINT_BIT]
        |=> !status_reg[ST_CINT_BIT];
    endproperty
    a_cint_w1c: assert property (p_cint_w1c)
        else $error("calibration flag not cleared");

endmodule

// ---- tb/pxc_host_model.sv ----
// Host model: I2C controller that reaches the core's registers.
// Assumes an SDA pull-up; the device pulls low through its oe_n only.
`timescale 1ns/1ps
module pxc_host_model
    import pxc_pkg::*;
(
    // clock
    input  wire logic i_clock,
    // device pins
    input  wire logic i_sda_out,
    input  wire logic i_sda_oe_n,
    output logic      o_scl,
    output logic      o_sda
);
    // ==================== wire resolution
    logic host_low = 1'b0;
    initial o_scl = 1'b1;
    // pull-up wins when nobody pulls low
    assign o_sda = ~host_low & (i_sda_oe_n | i_sda_out);

    // ==================== bus phases
    // 8 clocks a phase stays above the 2-clock minimum of the filter
    task automatic wait_n(input int n);
        repeat (n) @(posedge i_clock);
    endtask
    // sda moves mid low phase, never next to an scl edge
    task automatic bit_io(input logic b, output logic got);
        wait_n(4);
        host_low <= ~b;
        wait_n(4);
        o_scl <= 1'b1;
        wait_n(8);
        got = o_sda;
        o_scl <= 1'b0;
    endtask
    task automatic start();
        wait_n(4);
        host_low <= 1'b0;
        wait_n(4);
        o_scl <= 1'b1;
        wait_n(8);
        host_low <= 1'b1;
        wait_n(8);
        o_scl <= 1'b0;
    endtask
    task automatic stop();
        wait_n(4);
        host_low <= 1'b1;
        wait_n(4);
        o_scl <= 1'b1;
        wait_n(8);
        host_low <= 1'b0;
        wait_n(8);
    endtask
    task automatic send(input logic [7:0] d, inout logic ok);
        logic g;
        for (int i = 7; i >= 0; i--) bit_io(d[i], g);
        bit_io(1'b1, g);
        ok &= ~g;
    endtask

    // ==================== register transfers
    task automatic write_reg(input logic [6:0] dev, input logic [7:0] a,
                             input logic [7:0] d, output logic ok);
        ok = 1'b1;
        start();
        send({dev, 1'b0}, ok);
        send(a, ok);
        send(d, ok);
        stop();
    endtask
    // one byte then nack, so the pointer advances only once
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
        logic g;
        ok = 1'b1;
        start();
        send({I2C_ADDR, 1'b0}, ok);
        send(a, ok);
        start();
        send({I2C_ADDR, 1'b1}, ok);
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(1'b1, g);
        stop();
    endtask
endmodule

// ---- tb/pxc_core_tb.sv ----
// Testbench: registers through the host model, engines played by the bench.
// Assumes the package register map and a 125 MHz clock.
`timescale 1ns/1ps
module pxc_core_tb
    import pxc_pkg::*;
;
    // ==================== signals
    logic         i_clock = 1'b0;
    logic         i_rst = 1'b1;
    logic         i_power_on = 1'b0;
    logic         i_prox_valid = 1'b0;
    logic [7:0]   i_prox_count = 8'h00;
    logic [7:0]   i_status_set = 8'h00;
    logic         i_cal_done = 1'b0;
    pxc_cal_res_t i_cal_result = '0;
    logic         scl, sda, sda_out, sda_oe_n, int_out, int_oe_n, osc, cal_run, cal_elec;
    int           mismatches = 0;
    int           checks_done = 0;

    initial forever #4 i_clock = ~i_clock;

    pxc_core dut (.i_clock(i_clock), .i_rst(i_rst), .i_scl(scl), .i_sda(sda),
        .o_sda_out(sda_out), .o_sda_oe_n(sda_oe_n), .o_int_out(int_out),
        .o_int_oe_n(int_oe_n), .i_power_on(i_power_on), .o_osc_enable(osc),
        .i_prox_valid(i_prox_valid), .i_prox_count(i_prox_count),
        .i_status_set(i_status_set), .o_cal_run(cal_run), .o_cal_electrical(cal_elec),
        .i_cal_done(i_cal_done), .i_cal_result(i_cal_result));
    pxc_host_model host (.i_clock(i_clock), .i_sda_out(sda_out), .i_sda_oe_n(sda_oe_n),
        .o_scl(scl), .o_sda(sda));

    // ==================== helpers
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic ok;
        host.write_reg(I2C_ADDR, a, d, ok);
        check("write ack", 8'h01, {7'h00, ok});
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic       ok;
        host.read_reg(a, d, ok);
        check("read ack", 8'h01, {7'h00, ok});
        check($sformatf("reg %h", a), exp, d);
    endtask
    task automatic pin(ref logic s, input logic v, input string what);
        for (int n = 0; n < 40 && s !== v; n++) @(posedge i_clock);
        check(what, {7'h00, v}, {7'h00, s});
    endtask
    task automatic pulse(input logic [7:0] set, input logic prox, input logic done);
        @(posedge i_clock);
        i_status_set <= set;
        i_prox_valid <= prox;
        i_cal_done <= done;
        @(posedge i_clock);
        i_status_set <= 8'h00;
        i_prox_valid <= 1'b0;
        i_cal_done <= 1'b0;
    endtask

    // ==================== scenarios
    task automatic t_reset();
        logic ok;
        rd(ADDR_STATUS, STATUS_RST);
        rd(ADDR_INTERRUPT_SLEEP_CONFIG, INTERRUPT_SLEEP_CONFIG_RST);
        rd(ADDR_AUX, {4'h0, AUXILIARY_IDENT});
        rd(ADDR_OFS_MAG, OFS_RST);
        rd(ADDR_OFS_SIGN, OFS_RST);
        rd(ADDR_CAL, 8'h00);
        rd(8'hF0, 8'h00);
        host.write_reg(I2C_ADDR ^ 7'h01, ADDR_INTERRUPT_SLEEP_CONFIG, 8'h80, ok);
        check("foreign ack", 8'h00, {7'h00, ok});
        rd(ADDR_INTERRUPT_SLEEP_CONFIG, INTERRUPT_SLEEP_CONFIG_RST);
        check("osc off", 8'h00, {7'h00, osc});
        check("sda out level", 8'h00, {7'h00, sda_out});
        check("int out level", 8'h00, {7'h00, int_out});
        i_prox_count <= 8'hA5;
        pulse(8'h00, 1'b1, 1'b0);
        wr(ADDR_PROX, 8'h3C);
        rd(ADDR_PROX, 8'hA5);
        $display("test reset done");
    endtask
    task automatic t_autocal();
        @(posedge i_clock);
        i_power_on <= 1'b1;
        pin(cal_run, 1'b1, "auto run");
        check("auto mode", 8'h01, {7'h00, cal_elec});
        check("osc on", 8'h01, {7'h00, osc});
        rd(ADDR_CAL, 8'h21);
        i_cal_result <= 9'h15A;
        pulse(8'h00, 1'b0, 1'b1);
        pin(cal_run, 1'b0, "auto end");
        rd(ADDR_OFS_MAG, 8'h5A);
        rd(ADDR_OFS_SIGN, 8'h01);
        rd(ADDR_CAL, 8'h00);
        rd(ADDR_STATUS, 8'h08);
        rd(ADDR_STATUS, 8'h08);
        check("cal int", 8'h00, {7'h00, int_oe_n});
        wr(ADDR_STATUS, 8'h08);
        rd(ADDR_STATUS, 8'h00);
        check("int clear", 8'h01, {7'h00, int_oe_n});
        $display("test autocal done");
    endtask
    task automatic t_cal();
        wr(ADDR_CAL, 8'h01);
        pin(cal_run, 1'b1, "run");
        check("optical", 8'h00, {7'h00, cal_elec});
        wr(ADDR_CAL, 8'h00);
        pin(cal_run, 1'b0, "abort");
        rd(ADDR_CAL, 8'h00);
        i_cal_result <= 9'h0FF;
        pulse(8'h00, 1'b0, 1'b1);
        rd(ADDR_STATUS, 8'h00);
        rd(ADDR_OFS_MAG, 8'h5A);
        wr(ADDR_CAL, 8'h21);
        pin(cal_run, 1'b1, "elec run");
        check("electrical", 8'h01, {7'h00, cal_elec});
        i_cal_result <= 9'h033;
        pulse(8'h00, 1'b0, 1'b1);
        rd(ADDR_OFS_SIGN, 8'h00);
        rd(ADDR_OFS_MAG, 8'h33);
        rd(ADDR_CAL, 8'h00);
        $display("test cal done");
    endtask
    task automatic t_rdclr();
        wr(ADDR_INTERRUPT_SLEEP_CONFIG, 8'h8C);
        pulse(8'h20, 1'b0, 1'b0);
        rd(ADDR_STATUS, 8'h28);
        rd(ADDR_STATUS, 8'h00);
        check("int after read", 8'h01, {7'h00, int_oe_n});
        $display("test read clear done");
    endtask
    task automatic t_sleep();
        wr(ADDR_INTERRUPT_SLEEP_CONFIG, 8'h1C);
        pulse(8'h20, 1'b0, 1'b0);
        check("osc mid cycle", 8'h01, {7'h00, osc});
        pulse(8'h00, 1'b1, 1'b0);
        pin(osc, 1'b0, "sleep");
        rd(ADDR_INTERRUPT_SLEEP_CONFIG, 8'h1C);
        rd(ADDR_STATUS, 8'h20);
        wr(ADDR_STATUS, 8'h20);
        pin(osc, 1'b1, "wake");
        @(posedge i_clock);
        i_power_on <= 1'b0;
        pin(osc, 1'b0, "power off");
        i_power_on <= 1'b1;
        repeat (4) @(posedge i_clock);
        check("no second auto run", 8'h00, {7'h00, cal_run});
        $display("test sleep done");
    endtask

    // ==================== run control
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (3) @(posedge i_clock);
        i_rst <= 1'b0;
        repeat (6) @(posedge i_clock);
        t_reset();
        t_autocal();
        t_cal();
        t_rdclr();
        t_sleep();
        complete_run();
    end
    // about 40 transfers of under 1000 clocks each
    initial
    begin
        repeat (80000) @(posedge i_clock);
        mismatches++;
        complete_run();
    end
endmodule
